// ---- hw/cbt_timer.sv ----
// cascadable 8-bit timer/counter: control, timer registers, counter and output flop
//
// Behaviour
// - decode source clock codes into fast/slow/external ticks
// - low speed: only slow, slow/8, external, warm-up fast
// - run bit 0 stops and clears; 1 counts
// - mode 001 toggles output on period match
// - mode 010 generates pulse width modulation output
// - mode 011 makes this the lower byte
// - cascade: companion run and preset, own clock
// - control plus period and pulse-width registers
`timescale 1ns/1ps
module cbt_timer
   import cbt_pkg::*;
(
   input wire logic clk, // system clock, also the fast clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic [CBT_ADDR_W-1:0] addr, // register address
   input wire logic [CBT_DATA_W-1:0] wr_data, // register write data
   input wire logic wr_stb, // register write strobe
   input wire logic rd_stb, // register read strobe
   output logic [CBT_DATA_W-1:0] rd_data, // read data, cycle after rd_stb
   input wire logic slow_clock, // one-cycle tick per slow clock period
   input wire logic external_count_pin, // external count input
   input wire logic divider_select_bit, // routes slow/8 to code 000
   input wire logic low_speed_operation, // low-speed or low-speed-sleep state
   input wire logic warmup_count, // high-frequency warm-up counting active
   input wire logic companion_run_control, // companion run bit
   input wire logic companion_flop_preset, // companion flop preset bit
   input wire logic companion_clear, // companion match clears the pair
   output logic programmable_divider_output, // output flip-flop
   output logic match_pulse, // one-cycle pulse on period match
   output logic overflow_pulse // one-cycle carry to the companion
);
   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic [7:0] timer_five_control; // control register
   logic [7:0] period_compare_reg; // period/compare register
   logic [7:0] pulse_width_reg; // pulse-width register
   logic [7:0] pw_active; // pulse width in use this cycle
   logic [7:0] count; // up-counter
   logic [CBT_PRE_W-1:0] fast_pre; // free-running fast prescaler
   logic [2:0] slow_pre; // slow clock divider by eight
   logic ext_q; // previous external pin level
   logic run_q; // run state of previous cycle
   logic src_tick; // selected count tick
   logic eff_run; // run bit in charge this cycle
   logic eff_preset; // preset bit in charge this cycle
   logic start; // first cycle of a run
   logic wrap; // counter clears this tick
   cbt_mode_t mode; // decoded mode field
   logic [2:0] clk_sel; // source clock field

   // one tick of fast/2^n: low n prescaler bits all ones
   function automatic logic fast_tick(input logic [CBT_PRE_W-1:0] p, input int n);
      logic [CBT_PRE_W-1:0] mask;
      mask = CBT_PRE_W'((1 << n) - 1);
      return (p & mask) == mask;
   endfunction

   // register select helper
   function automatic logic hit(input logic [CBT_ADDR_W-1:0] a, input logic [CBT_ADDR_W-1:0] off);
      return a == off;
   endfunction

   assign mode = cbt_mode_t'(timer_five_control[CBT_MODE_HI:CBT_MODE_LO]);
   assign clk_sel = timer_five_control[CBT_CLK_HI:CBT_CLK_LO];

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // control register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_five_control <= CBT_CTRL_RESET;
      end else if (wr_stb && hit(addr, CBT_CTRL_OFFSET)) begin
         timer_five_control <= wr_data;
      end
   end

   // period and pulse-width registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         period_compare_reg <= CBT_PERIOD_RESET;
         pulse_width_reg <= CBT_PWIDTH_RESET;
      end else if (wr_stb) begin
         if (hit(addr, CBT_PERIOD_OFFSET)) begin
            period_compare_reg <= wr_data;
         end
         if (hit(addr, CBT_PWIDTH_OFFSET)) begin
            pulse_width_reg <= wr_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= CBT_ZERO;
      end else if (!rd_stb) begin
         rd_data <= CBT_ZERO;
      end else if (hit(addr, CBT_CTRL_OFFSET)) begin
         rd_data <= timer_five_control;
      end else if (hit(addr, CBT_PERIOD_OFFSET)) begin
         rd_data <= period_compare_reg;
      end else if (hit(addr, CBT_PWIDTH_OFFSET)) begin
         rd_data <= pulse_width_reg;
      end else if (hit(addr, CBT_COUNT_OFFSET)) begin
         rd_data <= count;
      end else begin
         rd_data <= CBT_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // prescalers and source selection
   // ----------------------------------------------------------------
   // fast prescaler runs always so the dividers stay in phase
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_pre <= '0;
      end else begin
         fast_pre <= fast_pre + 1'b1;
      end
   end

   // slow divider and external pin history
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_pre <= '0;
         ext_q <= 1'b0;
      end else begin
         ext_q <= external_count_pin;
         if (slow_clock) begin
            slow_pre <= slow_pre + 1'b1;
         end
      end
   end

   // source tick decode; in low speed the fast taps are unavailable
   always_comb begin
      src_tick = 1'b0;
      unique case (clk_sel)
         CBT_CK_DIV11: begin
            if (divider_select_bit || low_speed_operation) begin
               src_tick = slow_clock && (slow_pre == CBT_SLOW_DIV_LAST);
            end else begin
               src_tick = fast_tick(fast_pre, CBT_EXP_11);
            end
         end
         CBT_CK_DIV7: src_tick = !low_speed_operation && fast_tick(fast_pre, CBT_EXP_7);
         CBT_CK_DIV5: src_tick = !low_speed_operation && fast_tick(fast_pre, CBT_EXP_5);
         CBT_CK_DIV3: src_tick = !low_speed_operation && fast_tick(fast_pre, CBT_EXP_3);
         CBT_CK_SLOW: src_tick = slow_clock;
         CBT_CK_DIV1: src_tick = !low_speed_operation && fast_tick(fast_pre, CBT_EXP_1);
         CBT_CK_FAST: src_tick = !low_speed_operation || warmup_count;
         CBT_CK_EXT: src_tick = external_count_pin && !ext_q;
      endcase
   end

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   // in cascade the companion's run and preset bits govern the pair
   assign eff_run = (mode == CBT_MODE_CASCADE) ? companion_run_control
                                               : timer_five_control[CBT_RUN_BIT];
   assign eff_preset = (mode == CBT_MODE_CASCADE) ? companion_flop_preset
                                                  : timer_five_control[CBT_PRESET_BIT];
   assign start = eff_run && !run_q;

   // run history for start detection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 1'b0;
      end else begin
         run_q <= eff_run;
      end
   end

   // counter clears on period match except in PWM and cascade, which wrap
   always_comb begin
      wrap = 1'b0;
      unique case (mode)
         CBT_MODE_TIMER: wrap = count == period_compare_reg;
         CBT_MODE_DIVIDER: wrap = count == period_compare_reg;
         CBT_MODE_PWM: wrap = count == CBT_COUNT_MAX;
         CBT_MODE_CASCADE: wrap = count == CBT_COUNT_MAX;
         default: wrap = count == period_compare_reg;
      endcase
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= CBT_ZERO;
      end else if (!eff_run || start) begin
         count <= CBT_ZERO;
      end else if (mode == CBT_MODE_CASCADE && companion_clear) begin
         count <= CBT_ZERO;
      end else if (src_tick) begin
         count <= wrap ? CBT_ZERO : count + 1'b1;
      end
   end

   // event pulses: period match and carry into the companion
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         match_pulse <= 1'b0;
         overflow_pulse <= 1'b0;
      end else begin
         match_pulse <= eff_run && !start && src_tick && wrap
                        && (mode == CBT_MODE_TIMER || mode == CBT_MODE_DIVIDER);
         overflow_pulse <= eff_run && !start && src_tick && count == CBT_COUNT_MAX;
      end
   end

   // ----------------------------------------------------------------
   // output flip-flop
   // ----------------------------------------------------------------
   // pulse width is latched at start and at each PWM wrap so updates are glitch free
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pw_active <= CBT_PWIDTH_RESET;
      end else if (start || !eff_run || (mode == CBT_MODE_PWM && src_tick && wrap)) begin
         pw_active <= pulse_width_reg;
      end
   end

   // preset at start, toggle on divider match and on PWM width match and wrap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         programmable_divider_output <= 1'b0;
      end else if (start) begin
         programmable_divider_output <= eff_preset;
      end else if (eff_run && src_tick) begin
         if (mode == CBT_MODE_DIVIDER && wrap) begin
            programmable_divider_output <= !programmable_divider_output;
         end else if (mode == CBT_MODE_PWM && (count == pw_active || wrap)) begin
            programmable_divider_output <= !programmable_divider_output;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_src_div3;
      !low_speed_operation && clk_sel == CBT_CK_DIV3 && fast_pre[2:0] == 3'h7 |-> src_tick;
   endproperty
   a_src_div3: assert property (p_src_div3) else $error("fast/8 tick missing");

   property p_low_speed_block;
      low_speed_operation && (clk_sel == CBT_CK_DIV7 || clk_sel == CBT_CK_DIV1) |-> !src_tick;
   endproperty
   a_low_speed_block: assert property (p_low_speed_block) else $error("fast tap used in low speed");

   property p_stop_clear;
      !eff_run |=> count == CBT_ZERO;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not cleared");

   property p_divider_toggle;
      eff_run && !start && mode == CBT_MODE_DIVIDER && src_tick && count == period_compare_reg
         |=> programmable_divider_output != $past(programmable_divider_output) && count == CBT_ZERO;
   endproperty
   a_divider_toggle: assert property (p_divider_toggle) else $error("divider output did not toggle");

   property p_pwm_toggle;
      eff_run && !start && mode == CBT_MODE_PWM && src_tick && count == pw_active
         |=> programmable_divider_output != $past(programmable_divider_output);
   endproperty
   a_pwm_toggle: assert property (p_pwm_toggle) else $error("pwm output did not toggle");

   property p_carry;
      eff_run && !start && mode == CBT_MODE_CASCADE && !companion_clear && src_tick && count == CBT_COUNT_MAX
         |=> overflow_pulse ##1 !overflow_pulse || src_tick;
   endproperty
   a_carry: assert property (p_carry) else $error("cascade carry missing");

   property p_cascade_start;
      mode == CBT_MODE_CASCADE && $rose(companion_run_control)
         |=> programmable_divider_output == $past(companion_flop_preset);
   endproperty
   a_cascade_start: assert property (p_cascade_start) else $error("companion preset not loaded");

   property p_period_write;
      wr_stb && addr == CBT_PERIOD_OFFSET |=> period_compare_reg == $past(wr_data);
   endproperty
   a_period_write: assert property (p_period_write) else $error("period register not written");

   property p_timer_match;
      eff_run && !start && mode == CBT_MODE_TIMER && src_tick && count == period_compare_reg
         |=> match_pulse && count == CBT_ZERO;
   endproperty
   a_timer_match: assert property (p_timer_match) else $error("timer match did not clear");

   property p_preset_start;
      mode != CBT_MODE_CASCADE && $rose(timer_five_control[CBT_RUN_BIT])
         |=> programmable_divider_output == $past(timer_five_control[CBT_PRESET_BIT]);
   endproperty
   a_preset_start: assert property (p_preset_start) else $error("preset not loaded at start");

   c_divider_toggle: cover property (mode == CBT_MODE_DIVIDER && match_pulse);
   c_pwm_wrap: cover property (mode == CBT_MODE_PWM && eff_run && src_tick && wrap);
   c_cascade_carry: cover property (overflow_pulse);
   c_stop_run: cover property ($fell(eff_run));
endmodule // cbt_timer

// ---- hw/cbt_pkg.sv ----
// constants shared by the cascadable 8-bit timer control block
package cbt_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int CBT_ADDR_W = 16; // register address width
   localparam int CBT_DATA_W = 8; // register data width
   localparam logic [15:0] CBT_CTRL_OFFSET = 16'h0029; // timer_five_control
   localparam logic [15:0] CBT_PERIOD_OFFSET = 16'h0030; // period_compare_reg
   localparam logic [15:0] CBT_PWIDTH_OFFSET = 16'h0031; // pulse_width_reg
   localparam logic [15:0] CBT_COUNT_OFFSET = 16'h0032; // counter readback
   localparam logic [7:0] CBT_CTRL_RESET = 8'h00; // control reset value
   localparam logic [7:0] CBT_PERIOD_RESET = 8'hff; // period reset value
   localparam logic [7:0] CBT_PWIDTH_RESET = 8'h00; // pulse width reset value
   localparam logic [7:0] CBT_ZERO = 8'h00; // idle read data and cleared count
   localparam logic [7:0] CBT_COUNT_MAX = 8'hff; // last count before wrap

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CBT_PRESET_BIT = 7; // output_flop_preset
   localparam int CBT_CLK_HI = 6; // source_clock_select top
   localparam int CBT_CLK_LO = 4; // source_clock_select bottom
   localparam int CBT_RUN_BIT = 3; // run_control
   localparam int CBT_MODE_HI = 2; // mode_select top
   localparam int CBT_MODE_LO = 0; // mode_select bottom

   // ----------------------------------------------------------------
   // source clock codes and prescale exponents
   // ----------------------------------------------------------------
   localparam logic [2:0] CBT_CK_DIV11 = 3'h0; // fast/2^11 or slow/2^3
   localparam logic [2:0] CBT_CK_DIV7 = 3'h1; // fast/2^7
   localparam logic [2:0] CBT_CK_DIV5 = 3'h2; // fast/2^5
   localparam logic [2:0] CBT_CK_DIV3 = 3'h3; // fast/2^3
   localparam logic [2:0] CBT_CK_SLOW = 3'h4; // slow clock
   localparam logic [2:0] CBT_CK_DIV1 = 3'h5; // fast/2
   localparam logic [2:0] CBT_CK_FAST = 3'h6; // fast clock
   localparam logic [2:0] CBT_CK_EXT = 3'h7; // external count pin
   localparam int CBT_PRE_W = 11; // fast prescaler width
   localparam int CBT_EXP_11 = 11; // exponent of fast/2^11
   localparam int CBT_EXP_7 = 7; // exponent of fast/2^7
   localparam int CBT_EXP_5 = 5; // exponent of fast/2^5
   localparam int CBT_EXP_3 = 3; // exponent of fast/2^3
   localparam int CBT_EXP_1 = 1; // exponent of fast/2
   localparam logic [2:0] CBT_SLOW_DIV_LAST = 3'h7; // slow/2^3 terminal count

   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CBT_MODE_TIMER = 3'h0, // plain timer/event counter
      CBT_MODE_DIVIDER = 3'h1, // programmable divider output
      CBT_MODE_PWM = 3'h2, // pulse width modulation
      CBT_MODE_CASCADE = 3'h3 // lower byte of a 16-bit pair
   } cbt_mode_t;
endpackage

// ---- tb/cbt_timer_tb.sv ----
// self-checking testbench for the cascadable 8-bit timer control block
`timescale 1ns/1ps
module cascadable_8bit_timer_ctrl_tb_top;
   import cbt_pkg::*;
   // ----------------------------------------------------------------
   // stimulus and observation signals
   // ----------------------------------------------------------------
   logic clk; // 100 MHz system clock
   logic rst_b; // asynchronous reset, active low
   logic [CBT_ADDR_W-1:0] addr; // register address
   logic [CBT_DATA_W-1:0] wr_data; // register write data
   logic wr_stb; // write strobe
   logic rd_stb; // read strobe
   logic [CBT_DATA_W-1:0] rd_data; // read data
   logic slow_clock = 1'b0; // slow clock enable pulse
   logic ext_pin = 1'b0; // external count input
   logic div_sel; // routes slow/8 to code 000
   logic low_speed; // low-speed state
   logic warmup; // warm-up counting active
   logic comp_run; // companion run bit
   logic comp_preset; // companion preset bit
   logic comp_clear; // companion clear
   logic div_out; // output flop
   logic match_pulse; // period match pulse
   logic overflow_pulse; // carry to companion
   int mismatches; // failed comparisons
   int n_compared; // comparisons made
   int cyc = 0; // cycle counter for timeout and stimulus
   logic [7:0] v; // scratch read value

   // ----------------------------------------------------------------
   // design under test
   // ----------------------------------------------------------------
   cbt_timer u_cbt_timer (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .slow_clock(slow_clock), .external_count_pin(ext_pin),
      .divider_select_bit(div_sel), .low_speed_operation(low_speed), .warmup_count(warmup),
      .companion_run_control(comp_run), .companion_flop_preset(comp_preset), .companion_clear(comp_clear),
      .programmable_divider_output(div_out), .match_pulse(match_pulse), .overflow_pulse(overflow_pulse));

   // clock generator
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // slow tick every 16 cycles, external rising edge every 8 cycles, timeout guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      slow_clock <= (cyc[3:0] == 4'h0);
      if (cyc[1:0] == 2'h0) begin
         ext_pin <= ~ext_pin;
      end
      if (cyc == 40000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // bus tasks and comparison helpers
   // ----------------------------------------------------------------
   // one-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask

   // single comparison point
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // read and compare
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      rd(a, v);
      chk(v, exp, "register read");
   endtask

   // window check, unknowns fail
   task automatic rng(input logic [7:0] seen, input logic [7:0] lo, input logic [7:0] hi);
      logic ok;
      ok = (seen >= lo) && (seen <= hi);
      chk({7'h00, ok}, 8'h01, "value out of window");
   endtask

   // wait a bounded time for match (ovf 0) or overflow (ovf 1)
   task automatic wait_pulse(input bit ovf, input int lim);
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while (((ovf ? overflow_pulse : match_pulse) !== 1'b1) && i < lim);
      chk({7'h00, (ovf ? overflow_pulse : match_pulse)}, 8'h01, "pulse missing");
   endtask

   // run with one source clock code, check progress, stop and check clearing
   task automatic clk_code(input logic [2:0] c, input int w, input logic [7:0] lo, input logic [7:0] hi);
      wr(CBT_CTRL_OFFSET, {1'b0, c, 1'b1, 3'h0});
      repeat (w) @(posedge clk);
      rd(CBT_COUNT_OFFSET, v);
      rng(v, lo, hi);
      wr(CBT_CTRL_OFFSET, {1'b0, c, 1'b0, 3'h0});
      rchk(CBT_COUNT_OFFSET, CBT_ZERO);
   endtask

   // one pwm period after the next wrap: shorter phase equals the width
   task automatic pwm_period(input logic [7:0] w);
      int hi;
      hi = 0;
      wait_pulse(1'b1, 300);
      repeat (256) begin
         @(posedge clk);
         #1 hi += (div_out === 1'b1) ? 1 : 0;
      end
      rng(8'(hi < 128 ? hi : 256 - hi), w - 8'h01, w + 8'h01);
   endtask

   // verdict and end of run
   task automatic final_report();
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_b, addr, wr_data, wr_stb, rd_stb, div_sel} = '0;
      {low_speed, warmup, comp_run, comp_preset, comp_clear} = '0;
      mismatches = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      // reset values, read-only count, unmapped place
      rchk(CBT_CTRL_OFFSET, CBT_CTRL_RESET);
      rchk(CBT_PWIDTH_OFFSET, CBT_PWIDTH_RESET);
      rchk(16'h002a, CBT_ZERO);
      // period reads back non-zero, so the release check below can trip
      rchk(CBT_PERIOD_OFFSET, CBT_PERIOD_RESET);
      @(posedge clk);
      #1 chk(rd_data, CBT_ZERO, "read data not released");
      wr(CBT_PERIOD_OFFSET, 8'h02);
      wr(CBT_PWIDTH_OFFSET, 8'h5a);
      wr(CBT_CTRL_OFFSET, 8'h54);
      wr(16'h002a, 8'hff);
      wr(CBT_COUNT_OFFSET, 8'h77);
      rchk(CBT_PERIOD_OFFSET, 8'h02);
      rchk(CBT_PWIDTH_OFFSET, 8'h5a);
      rchk(CBT_CTRL_OFFSET, 8'h54);
      rchk(16'h002a, CBT_ZERO);
      rchk(CBT_COUNT_OFFSET, CBT_ZERO);
      // divider output, period 2, preset 0: toggle every 3 ticks
      wr(CBT_CTRL_OFFSET, 8'h69);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, div_out}, 8'h00, "preset 0 not loaded");
      wait_pulse(1'b0, 20);
      chk({7'h00, div_out}, 8'h01, "divider output not toggled");
      repeat (3) @(posedge clk);
      #1 chk({6'h00, match_pulse, div_out}, 8'h02, "divider second toggle");
      wr(CBT_CTRL_OFFSET, 8'h61);
      rchk(CBT_COUNT_OFFSET, CBT_ZERO);
      // preset 1 with a long period
      wr(CBT_PERIOD_OFFSET, CBT_COUNT_MAX);
      wr(CBT_CTRL_OFFSET, 8'he9);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, div_out}, 8'h01, "preset 1 not loaded");
      wr(CBT_CTRL_OFFSET, 8'he1);
      // cascade: companion bits start the pair and preset the flop
      wr(CBT_CTRL_OFFSET, 8'h63);
      @(posedge clk);
      comp_run <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({7'h00, div_out}, 8'h00, "companion preset not loaded");
      repeat (5) @(posedge clk);
      rd(CBT_COUNT_OFFSET, v);
      rng(v, 8'h06, 8'h0b);
      @(posedge clk);
      comp_clear <= 1'b1;
      @(posedge clk);
      comp_clear <= 1'b0;
      rd(CBT_COUNT_OFFSET, v);
      rng(v, 8'h00, 8'h03);
      wait_pulse(1'b1, 300);
      @(posedge clk);
      comp_run <= 1'b0;
      repeat (2) @(posedge clk);
      rchk(CBT_COUNT_OFFSET, CBT_ZERO);
      // plain timer, period 4: match every 5 ticks, flop untouched
      wr(CBT_PERIOD_OFFSET, 8'h04);
      wr(CBT_CTRL_OFFSET, 8'h68);
      wait_pulse(1'b0, 20);
      repeat (4) @(posedge clk);
      #1 chk({6'h00, match_pulse, div_out}, 8'h00, "early match or toggle");
      @(posedge clk);
      #1 chk({6'h00, match_pulse, div_out}, 8'h02, "match period");
      wr(CBT_CTRL_OFFSET, 8'h60);
      wr(CBT_PERIOD_OFFSET, CBT_COUNT_MAX);
      // pwm, width change while running
      wr(CBT_PWIDTH_OFFSET, 8'h10);
      wr(CBT_CTRL_OFFSET, 8'h6a);
      pwm_period(8'h10);
      wr(CBT_PWIDTH_OFFSET, 8'h40);
      pwm_period(8'h40);
      wr(CBT_CTRL_OFFSET, 8'h62);
      // source clock codes, eight ticks expected each
      clk_code(CBT_CK_FAST, 8, 8'h06, 8'h0a);
      clk_code(CBT_CK_DIV1, 16, 8'h06, 8'h0a);
      clk_code(CBT_CK_DIV3, 64, 8'h06, 8'h0a);
      clk_code(CBT_CK_DIV5, 256, 8'h06, 8'h0a);
      clk_code(CBT_CK_DIV7, 1024, 8'h06, 8'h0a);
      clk_code(CBT_CK_DIV11, 16384, 8'h06, 8'h0a);
      clk_code(CBT_CK_SLOW, 128, 8'h06, 8'h0a);
      clk_code(CBT_CK_EXT, 64, 8'h06, 8'h0a);
      @(posedge clk);
      div_sel <= 1'b1;
      clk_code(CBT_CK_DIV11, 1024, 8'h06, 8'h0a);
      // low speed: slow sources only, fast only while warming up
      @(posedge clk);
      div_sel <= 1'b0;
      low_speed <= 1'b1;
      clk_code(CBT_CK_DIV11, 1024, 8'h06, 8'h0a);
      clk_code(CBT_CK_SLOW, 128, 8'h06, 8'h0a);
      clk_code(CBT_CK_DIV7, 512, 8'h00, 8'h00);
      clk_code(CBT_CK_DIV1, 64, 8'h00, 8'h00);
      clk_code(CBT_CK_FAST, 64, 8'h00, 8'h00);
      @(posedge clk);
      warmup <= 1'b1;
      clk_code(CBT_CK_FAST, 8, 8'h06, 8'h0a);
      final_report();
   end
endmodule // cascadable_8bit_timer_ctrl_tb_top
